// [hdl/pcb_pkg.sv]
// Behaviour
// - six registers plus latch per cell
// - ddr uses both in regs, latch, out regs
// - one enable register on falling edge
// - at most four cells per block
// - eight block clock lines per block
// - each cell selects its own controls
// - block clocks reach controls via local routing
// - input clock and enable are separate
// - output and enable regs share clock, enable
// - every cell input may be inverted
// - one clear/set source, clear or set chosen
// - power-up level picks clear or set
// - synchronous clear also available
// - column drives column only, row drives all
// - ddr out: first bit high, second low
// - latch holds high-time data, aligned capture
// - falling enable reg delays enable till fall
package pcb_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 32;
	localparam logic [5:0] SEL_BASE = 6'h00;
	localparam logic [5:0] MODE_BASE = 6'h10;
	localparam logic [5:0] STATUS_ADDR = 6'h20;
	localparam int SEL_W = 28;
	localparam int MODE_W = 14;
	localparam logic [27:0] SEL_RESET = 28'h8888888;
	localparam logic [13:0] MODE_RESET = 14'h0000;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int FS_W = 4;
	localparam int F_CLK_IN = 0;
	localparam int F_CLK_OUT = 4;
	localparam int F_CE_IN = 8;
	localparam int F_CE_OUT = 12;
	localparam int F_OE = 16;
	localparam int F_ACLR = 20;
	localparam int F_SCLR = 24;
	localparam int M_DDR_IN = 0;
	localparam int M_DDR_OUT = 1;
	localparam int M_NEG_OE = 2;
	localparam int M_PWR_HIGH = 3;
	localparam int M_INV = 4;
	localparam int I_CLK_IN = 0;
	localparam int I_CLK_OUT = 1;
	localparam int I_CE_IN = 2;
	localparam int I_CE_OUT = 3;
	localparam int I_OE = 4;
	localparam int I_ACLR = 5;
	localparam int I_SCLR = 6;
	localparam int I_DA = 7;
	localparam int I_DB = 8;
	localparam int I_PAD = 9;
	localparam int ST_PAD = 0;
	localparam int ST_OE = 4;
	localparam int ST_CAP_A = 8;
	localparam int ST_CAP_B = 12;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int MAX_CELLS = 4;
	localparam int CORE_LINES = 4;
	localparam int BLK_CLKS = 8;
endpackage : pcb_pkg

// [hdl/pcb_cell.sv]
`timescale 1ns/100ps
module pcb_cell
(
	input wire logic clock,
	input wire logic rst,
	input wire logic in_rise,
	input wire logic in_hi,
	input wire logic out_rise,
	input wire logic out_fall,
	input wire logic out_hi,
	input wire logic ce_in,
	input wire logic ce_out,
	input wire logic aclr,
	input wire logic sclr,
	input wire logic dout_a,
	input wire logic dout_b,
	input wire logic oe_req,
	input wire logic pad_lvl,
	input wire logic ddr_in,
	input wire logic ddr_out,
	input wire logic neg_oe,
	input wire logic init,
	output logic pad_o,
	output logic pad_oe,
	output logic cap_a,
	output logic cap_b
);
	logic in_lat;
	logic out_a;
	logic out_b;
	logic oe_p;
	logic oe_n;
	logic in_en;
	logic out_en;

	assign in_en = in_rise && ce_in;
	assign out_en = out_rise && ce_out;

	// ------------------------------------------------------------
	// input capture
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cap_a <= 1'b0;
			cap_b <= 1'b0;
			in_lat <= 1'b0;
		end
		else if (aclr)
		begin
			cap_a <= init;
			cap_b <= init;
			in_lat <= init;
		end
		else
		begin
			if (ddr_in && in_hi && ce_in)
				in_lat <= pad_lvl;
			if (in_en)
			begin
				cap_a <= sclr ? init : pad_lvl;
				if (ddr_in)
					cap_b <= sclr ? init : in_lat;
			end
		end
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			out_a <= 1'b0;
			out_b <= 1'b0;
		end
		else if (aclr)
		begin
			out_a <= init;
			out_b <= init;
		end
		else if (out_en)
		begin
			out_a <= sclr ? init : dout_a;
			out_b <= sclr ? init : dout_b;
		end
	end

	// ------------------------------------------------------------
	// drive enable registers
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			oe_p <= 1'b0;
			oe_n <= 1'b0;
		end
		else if (aclr)
		begin
			oe_p <= init;
			oe_n <= init;
		end
		else
		begin
			if (out_en)
				oe_p <= sclr ? init : oe_req;
			if (out_fall && ce_out)
				oe_n <= sclr ? init : oe_p;
		end
	end

	// first bit while clock high, second while low
	assign pad_o = (ddr_out && !out_hi) ? out_b : out_a;
	assign pad_oe = neg_oe ? (oe_p && oe_n) : oe_p;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_ddr_out_order;
		(ddr_out && out_en && !aclr && !sclr ##1 ddr_out && out_hi)
			|-> pad_o == $past(dout_a);
	endproperty
	a_ddr_out_order: assert property (p_ddr_out_order)
		else $error("ddr first bit not on pad in high time");

	property p_oe_waits_fall;
		(neg_oe && !oe_n && out_en && !aclr && !out_fall)
			|=> !pad_oe;
	endproperty
	a_oe_waits_fall: assert property (p_oe_waits_fall)
		else $error("pad enabled before falling edge");

	property p_aclr_all;
		aclr |=> (cap_a == $past(init)) && (out_a == $past(init))
			&& (oe_p == $past(init)) && (oe_n == $past(init));
	endproperty
	a_aclr_all: assert property (p_aclr_all)
		else $error("clear or set missed a register");

	property p_sclr_sync;
		(sclr && !aclr && !in_en && !out_en) |=> $stable(out_a)
			&& $stable(cap_a);
	endproperty
	a_sclr_sync: assert property (p_sclr_sync)
		else $error("sync clear acted without clock edge");

	property p_ddr_in_pair;
		(ddr_in && in_en && !aclr && !sclr) |=> cap_a == $past(pad_lvl)
			&& cap_b == $past(in_lat);
	endproperty
	a_ddr_in_pair: assert property (p_ddr_in_pair)
		else $error("ddr input pair not aligned");

	c_ddr_in: cover property (ddr_in && in_en ##1 ddr_in && in_hi);
	c_ddr_out: cover property (ddr_out && out_en ##[1:4] !out_hi);
	c_neg_oe: cover property (neg_oe && $rose(pad_oe));
	c_aclr: cover property (aclr && init);
endmodule : pcb_cell

// [hdl/pcb_block.sv]
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
module pcb_block
#(
	parameter int NUM_CELLS = 4,
	parameter bit IS_ROW = 1'b1
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [5:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [7:0] blk_clk,
	input wire logic [3:0] io_clk,
	input wire logic [3:0] data_a,
	input wire logic [3:0] data_b,
	input wire logic [3:0] oe_core,
	input wire logic [3:0] ce_in_core,
	input wire logic [3:0] ce_out_core,
	input wire logic [3:0] aclr_core,
	input wire logic [3:0] sclr_core,
	input wire logic [NUM_CELLS-1:0] pad_i,
	output logic [NUM_CELLS-1:0] pad_o,
	output logic [NUM_CELLS-1:0] pad_oe,
	output logic [2*NUM_CELLS-1:0] to_column,
	output logic [2*NUM_CELLS-1:0] to_row,
	output logic [2*NUM_CELLS-1:0] to_direct
);
	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	generate
		if (NUM_CELLS < 1 || NUM_CELLS > pcb_pkg::MAX_CELLS)
		begin : g_bad_cells
			$error("cell count must be 1 to 4");
		end
	endgenerate

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// picks a core line or, via local routing, a block clock line
	function automatic logic pcb_pick
	(
		input logic [3:0] core,
		input logic [7:0] blk,
		input logic [3:0] sel,
		input logic inv
	);
		logic v;
		v = sel[3] ? core[sel[1:0]] : blk[sel[2:0]];
		return v ^ inv;
	endfunction : pcb_pick

	// address of register number idx in a bank
	function automatic logic pcb_hit
	(
		input logic [5:0] a,
		input logic [5:0] base,
		input int idx
	);
		logic [5:0] off;
		off = 6'(idx * 4);
		return a == (base + off);
	endfunction : pcb_hit

	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [pcb_pkg::SEL_W-1:0] sel_reg [NUM_CELLS];
	logic [pcb_pkg::MODE_W-1:0] mode_reg [NUM_CELLS];

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < NUM_CELLS; i++)
		begin
			if (rst)
				sel_reg[i] <= pcb_pkg::SEL_RESET;
			else if (wr && pcb_hit(addr, pcb_pkg::SEL_BASE, i))
				sel_reg[i] <= wdata[pcb_pkg::SEL_W-1:0];
		end
	end

	always_ff @(posedge clock)
	begin
		for (int i = 0; i < NUM_CELLS; i++)
		begin
			if (rst)
				mode_reg[i] <= pcb_pkg::MODE_RESET;
			else if (wr && pcb_hit(addr, pcb_pkg::MODE_BASE, i))
				mode_reg[i] <= wdata[pcb_pkg::MODE_W-1:0];
		end
	end

	// ------------------------------------------------------------
	// pad input synchronisers
	// ------------------------------------------------------------
	logic [NUM_CELLS-1:0] pad_s1;
	logic [NUM_CELLS-1:0] pad_s2;
	logic [NUM_CELLS-1:0] pad_s3;
	logic [NUM_CELLS-1:0] pad_lvl;
	logic [NUM_CELLS-1:0] pad_agree;

	assign pad_agree = pad_s2 ~^ pad_s3;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			pad_s1 <= '0;
			pad_s2 <= '0;
			pad_s3 <= '0;
		end
		else
		begin
			pad_s1 <= pad_i;
			pad_s2 <= pad_s1;
			pad_s3 <= pad_s2;
		end
	end

	// level moves only once two stages agree
	always_ff @(posedge clock)
	begin
		if (rst)
			pad_lvl <= '0;
		else
			pad_lvl <= (pad_agree & pad_s3) | (~pad_agree & pad_lvl);
	end

	// ------------------------------------------------------------
	// per cell control selection and clock edges
	// ------------------------------------------------------------
	logic [NUM_CELLS-1:0] in_lvl;
	logic [NUM_CELLS-1:0] out_lvl;
	logic [NUM_CELLS-1:0] in_prev;
	logic [NUM_CELLS-1:0] out_prev;
	logic [NUM_CELLS-1:0] in_rise;
	logic [NUM_CELLS-1:0] out_rise;
	logic [NUM_CELLS-1:0] out_fall;
	logic [NUM_CELLS-1:0] ce_in;
	logic [NUM_CELLS-1:0] ce_out;
	logic [NUM_CELLS-1:0] oe_req;
	logic [NUM_CELLS-1:0] aclr;
	logic [NUM_CELLS-1:0] sclr;
	logic [NUM_CELLS-1:0] cap_a;
	logic [NUM_CELLS-1:0] cap_b;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			in_prev <= '0;
			out_prev <= '0;
		end
		else
		begin
			in_prev <= in_lvl;
			out_prev <= out_lvl;
		end
	end

	assign in_rise = in_lvl & ~in_prev;
	assign out_rise = out_lvl & ~out_prev;
	assign out_fall = ~out_lvl & out_prev;

	generate
		for (genvar i = 0; i < NUM_CELLS; i++)
		begin : g_cell
			logic [pcb_pkg::SEL_W-1:0] s;
			logic [pcb_pkg::MODE_W-1:0] m;
			logic [9:0] inv;
			logic cell_init;

			assign s = sel_reg[i];
			assign m = mode_reg[i];
			assign inv = m[pcb_pkg::M_INV +: 10];
			assign cell_init = m[pcb_pkg::M_PWR_HIGH];

			assign in_lvl[i] = pcb_pick(io_clk, blk_clk,
				s[pcb_pkg::F_CLK_IN +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_CLK_IN]);
			assign out_lvl[i] = pcb_pick(io_clk, blk_clk,
				s[pcb_pkg::F_CLK_OUT +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_CLK_OUT]);
			assign ce_in[i] = pcb_pick(ce_in_core, blk_clk,
				s[pcb_pkg::F_CE_IN +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_CE_IN]);
			assign ce_out[i] = pcb_pick(ce_out_core, blk_clk,
				s[pcb_pkg::F_CE_OUT +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_CE_OUT]);
			assign oe_req[i] = pcb_pick(oe_core, blk_clk,
				s[pcb_pkg::F_OE +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_OE]);
			// one source for every register of the cell
			assign aclr[i] = pcb_pick(aclr_core, blk_clk,
				s[pcb_pkg::F_ACLR +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_ACLR]);
			assign sclr[i] = pcb_pick(sclr_core, blk_clk,
				s[pcb_pkg::F_SCLR +: pcb_pkg::FS_W],
				inv[pcb_pkg::I_SCLR]);

			pcb_cell u_cell
			(
				.clock(clock),
				.rst(rst),
				.in_rise(in_rise[i]),
				.in_hi(in_lvl[i]),
				.out_rise(out_rise[i]),
				.out_fall(out_fall[i]),
				.out_hi(out_lvl[i]),
				.ce_in(ce_in[i]),
				.ce_out(ce_out[i]),
				.aclr(aclr[i]),
				.sclr(sclr[i]),
				.dout_a(data_a[i] ^ inv[pcb_pkg::I_DA]),
				.dout_b(data_b[i] ^ inv[pcb_pkg::I_DB]),
				.oe_req(oe_req[i]),
				.pad_lvl(pad_lvl[i] ^ inv[pcb_pkg::I_PAD]),
				.ddr_in(m[pcb_pkg::M_DDR_IN]),
				.ddr_out(m[pcb_pkg::M_DDR_OUT]),
				.neg_oe(m[pcb_pkg::M_NEG_OE]),
				.init(cell_init),
				.pad_o(pad_o[i]),
				.pad_oe(pad_oe[i]),
				.cap_a(cap_a[i]),
				.cap_b(cap_b[i])
			);

			assign to_column[2*i] = cap_a[i];
			assign to_column[2*i+1] = cap_b[i];
		end
	endgenerate

	// ------------------------------------------------------------
	// interconnect drive
	// ------------------------------------------------------------
	generate
		if (IS_ROW)
		begin : g_row
			assign to_row = to_column;
			assign to_direct = to_column;
		end
		else
		begin : g_col
			assign to_row = '0;
			assign to_direct = '0;
		end
	endgenerate

	// ------------------------------------------------------------
	// register read
	// ------------------------------------------------------------
	logic [31:0] next_rdata;

	always_comb
	begin
		next_rdata = '0;
		for (int i = 0; i < NUM_CELLS; i++)
		begin
			if (pcb_hit(addr, pcb_pkg::SEL_BASE, i))
				next_rdata = {4'h0, sel_reg[i]};
			if (pcb_hit(addr, pcb_pkg::MODE_BASE, i))
				next_rdata = {18'h00000, mode_reg[i]};
		end
		if (addr == pcb_pkg::STATUS_ADDR)
		begin
			for (int i = 0; i < NUM_CELLS; i++)
			begin
				next_rdata[pcb_pkg::ST_PAD + i] = pad_lvl[i];
				next_rdata[pcb_pkg::ST_OE + i] = pad_oe[i];
				next_rdata[pcb_pkg::ST_CAP_A + i] = cap_a[i];
				next_rdata[pcb_pkg::ST_CAP_B + i] = cap_b[i];
			end
		end
	end

	// data stand only in the cycle after the read
	always_ff @(posedge clock)
	begin
		if (rst)
			rdata <= '0;
		else if (rd)
			rdata <= next_rdata;
		else
			rdata <= '0;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	property p_sel_readback;
		(wr && addr == pcb_pkg::SEL_BASE ##1 rd && !wr
			&& addr == pcb_pkg::SEL_BASE)
			|=> rdata == ($past(wdata, 2) & 32'h0FFFFFFF);
	endproperty
	a_sel_readback: assert property (p_sel_readback)
		else $error("selection register readback wrong");

	property p_pad_filter;
		(pad_i[0])[*5] |-> pad_lvl[0];
	endproperty
	a_pad_filter: assert property (p_pad_filter)
		else $error("pad level not settled after five cycles");

	property p_column_quiet;
		!IS_ROW |-> to_row == '0 && to_direct == '0;
	endproperty
	a_column_quiet: assert property (p_column_quiet)
		else $error("column block drove row interconnect");

	property p_row_mirror;
		IS_ROW |-> to_row == to_column && to_direct == to_column;
	endproperty
	a_row_mirror: assert property (p_row_mirror)
		else $error("row block lost captured data on row or direct");

	property p_rdata_idle;
		!rd |=> rdata == '0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data stood outside the read cycle");

	property p_pad_low_filter;
		(!pad_i[0])[*5] |-> !pad_lvl[0];
	endproperty
	a_pad_low_filter: assert property (p_pad_low_filter)
		else $error("pad low level not settled after five cycles");

	property p_oe_off_release;
		(!mode_reg[0][pcb_pkg::M_NEG_OE] && out_rise[0] && ce_out[0]
			&& !oe_req[0] && !aclr[0] && !sclr[0]) |=> !pad_oe[0];
	endproperty
	a_oe_off_release: assert property (p_oe_off_release)
		else $error("pad still driven after enable dropped");

	c_status_read: cover property (rd && addr == pcb_pkg::STATUS_ADDR);
endmodule : pcb_block

// [verification/pcb_pin_model.sv]
`timescale 1ns/100ps
module pcb_pin_model
(
	input wire logic [3:0] pad_o,
	input wire logic [3:0] pad_oe,
	input wire logic [3:0] ext_val,
	output logic [3:0] pad_i
);
	// ------------------------------------------------------------
	// pin level
	// ------------------------------------------------------------
	// far device drives whenever the cell lets go of the pin
	always_comb
	begin
		pad_i = (pad_oe & pad_o) | (~pad_oe & ext_val);
	end
endmodule : pcb_pin_model

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [5:0] addr = 6'h00;
	logic [31:0] wdata = 32'h00000000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic [7:0] blk_clk = 8'h00;
	logic [3:0] io_clk = 4'h0;
	logic [3:0] data_a = 4'h0;
	logic [3:0] data_b = 4'h0;
	logic [3:0] oe_core = 4'h0;
	logic [3:0] ce_in_core = 4'h1;
	logic [3:0] ce_out_core = 4'h1;
	logic [3:0] aclr_core = 4'h0;
	logic [3:0] sclr_core = 4'h0;
	logic [3:0] ext_val = 4'h0;
	logic [3:0] pad_i, pad_o, pad_oe, r, s;
	logic [7:0] to_column, to_row, to_direct;
	logic [31:0] w;
	int err_total = 0;
	int comparisons = 0;
	int cycles = 0;

	initial
	begin
		forever #4 clock = ~clock;
	end

	pcb_block #(.NUM_CELLS(4), .IS_ROW(1'b1)) i_dut
	(
		.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .blk_clk(blk_clk), .io_clk(io_clk),
		.data_a(data_a), .data_b(data_b), .oe_core(oe_core),
		.ce_in_core(ce_in_core), .ce_out_core(ce_out_core),
		.aclr_core(aclr_core), .sclr_core(sclr_core), .pad_i(pad_i),
		.pad_o(pad_o), .pad_oe(pad_oe), .to_column(to_column),
		.to_row(to_row), .to_direct(to_direct)
	);

	pcb_pin_model i_pin
	(
		.pad_o(pad_o), .pad_oe(pad_oe), .ext_val(ext_val), .pad_i(pad_i)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic complete_run;
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task automatic chk_pin(input logic [3:0] got, input logic [3:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: pin %h exp %h", $time, got, exp);
		end
	endtask : chk_pin

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: reg %h exp %h", $time, got, exp);
		end
	endtask : chk_reg

	task automatic hold(input int n);
		repeat (n) @(posedge clock);
	endtask : hold

	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		@(posedge clock);
	endtask : bus_wr

	task automatic bus_rd(input logic [5:0] a, input logic [31:0] e);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		chk_reg(rdata, e);
		@(posedge clock);
	endtask : bus_rd

	// write then read with no gap between the strobes
	task automatic bus_wr_rd(input logic [5:0] a, input logic [31:0] d,
		input logic [31:0] e);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		chk_reg(rdata, e);
		@(posedge clock);
	endtask : bus_wr_rd

	task automatic set_all(input logic [5:0] base, input logic [31:0] v);
		for (int i = 0; i < 4; i++)
			bus_wr(base + 6'(4 * i), v);
	endtask : set_all

	// one full period on a block line (b < 8) or core clock line 0
	task automatic tick(input int b);
		if (b < 8)
			blk_clk[b] <= 1'b1;
		else
			io_clk[0] <= 1'b1;
		hold(4);
		if (b < 8)
			blk_clk[b] <= 1'b0;
		else
			io_clk[0] <= 1'b0;
		hold(4);
	endtask : tick

	// every second bit, from offset o
	function automatic logic [3:0] pick(input logic [7:0] v, input int o);
		return {v[6 + o], v[4 + o], v[2 + o], v[o]};
	endfunction : pick

	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			err_total++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(80));
		hold(12);
		rst <= 1'b0;
		hold(1);
		for (int i = 0; i < 4; i++)
		begin
			bus_rd(6'(4 * i), 32'(pcb_pkg::SEL_RESET));
			bus_rd(pcb_pkg::MODE_BASE + 6'(4 * i), 32'h00000000);
		end
		bus_rd(6'h3C, 32'h00000000);
		repeat (4)
		begin
			w = $urandom;
			bus_wr_rd(pcb_pkg::SEL_BASE, w, w & 32'h0FFFFFFF);
			bus_wr(6'h04, w);
			bus_rd(6'h04, w & 32'h0FFFFFFF);
			bus_wr(6'h14, w);
			bus_rd(6'h14, w & 32'h00003FFF);
		end
		bus_wr(pcb_pkg::SEL_BASE, 32'(pcb_pkg::SEL_RESET));
		bus_wr(6'h04, 32'(pcb_pkg::SEL_RESET));
		bus_wr(6'h14, 32'h00000000);
		oe_core <= 4'h1;
		repeat (8)
		begin
			r = 4'($urandom);
			data_a <= r;
			tick(8);
			chk_pin(pad_o, r);
			chk_pin(pad_oe, 4'hF);
		end
		ce_out_core <= 4'h0;
		oe_core <= 4'h0;
		data_a <= ~r;
		tick(8);
		chk_pin(pad_o, r);
		chk_pin(pad_oe, 4'hF);
		ce_out_core <= 4'h1;
		oe_core <= 4'h1;
		set_all(pcb_pkg::MODE_BASE, 32'h00000800);
		tick(8);
		chk_pin(pad_o, r);
		set_all(pcb_pkg::MODE_BASE, 32'h00000002);
		r = 4'($urandom);
		s = ~r;
		data_a <= r;
		data_b <= s;
		io_clk[0] <= 1'b1;
		hold(4);
		chk_pin(pad_o, r);
		io_clk[0] <= 1'b0;
		hold(4);
		chk_pin(pad_o, s);
		set_all(pcb_pkg::MODE_BASE, 32'h00000006);
		oe_core <= 4'h0;
		tick(8);
		oe_core <= 4'h1;
		io_clk[0] <= 1'b1;
		hold(4);
		chk_pin(pad_oe, 4'h0);
		io_clk[0] <= 1'b0;
		hold(4);
		chk_pin(pad_oe, 4'hF);
		set_all(pcb_pkg::MODE_BASE, 32'h00000000);
		data_a <= 4'hF;
		tick(8);
		sclr_core <= 4'h1;
		tick(8);
		chk_pin(pad_o, 4'h0);
		sclr_core <= 4'h0;
		tick(8);
		aclr_core <= 4'h1;
		hold(3);
		chk_pin(pad_o, 4'h0);
		chk_pin(pad_oe, 4'h0);
		aclr_core <= 4'h0;
		set_all(pcb_pkg::MODE_BASE, 32'h00000008);
		aclr_core <= 4'h1;
		hold(3);
		chk_pin(pad_o, 4'hF);
		chk_pin(pad_oe, 4'hF);
		aclr_core <= 4'h0;
		set_all(pcb_pkg::MODE_BASE, 32'h00000000);
		oe_core <= 4'h0;
		tick(8);
		r = 4'($urandom);
		ext_val <= r;
		hold(6);
		tick(8);
		chk_pin(pick(to_column, 0), r);
		chk_pin(pick(to_row, 0), r);
		chk_pin(pick(to_direct, 0), r);
		set_all(pcb_pkg::MODE_BASE, 32'h00002000);
		tick(8);
		chk_pin(pick(to_column, 0), ~r);
		set_all(pcb_pkg::MODE_BASE, 32'h00000000);
		tick(8);
		set_all(pcb_pkg::SEL_BASE, 32'h08888381);
		ext_val <= ~r;
		hold(6);
		tick(8);
		chk_pin(pick(to_column, 0), r);
		tick(1);
		chk_pin(pick(to_column, 0), r);
		blk_clk <= 8'h08;
		hold(1);
		tick(1);
		chk_pin(pick(to_column, 0), ~r);
		set_all(pcb_pkg::SEL_BASE, 32'(pcb_pkg::SEL_RESET));
		set_all(pcb_pkg::MODE_BASE, 32'h00000001);
		r = 4'($urandom);
		s = 4'($urandom);
		ext_val <= s;
		io_clk[0] <= 1'b1;
		hold(6);
		io_clk[0] <= 1'b0;
		hold(2);
		ext_val <= r;
		hold(6);
		io_clk[0] <= 1'b1;
		hold(6);
		chk_pin(pick(to_column, 0), r);
		chk_pin(pick(to_column, 1), s);
		bus_rd(pcb_pkg::STATUS_ADDR, {16'h0000, s, r, 4'h0, r});
		complete_run();
	end
endmodule : tb
